/* shared/lalarm_pkg.sv */
// Purpose: Constants and types of the line alarm status block.
// Assumes: A 50 MHz system clock and a 32-bit APB register bus.
// Notes: Byte address of a register is four times its index.
`default_nettype none
package lalarm_pkg;
    localparam int LALARM_CLK_HZ      = 50_000_000;
    localparam int LALARM_TICK_US     = 1000;
    localparam int LALARM_TICK_CYCLES = LALARM_CLK_HZ / 1_000_000 * LALARM_TICK_US;
    localparam int LALARM_QUAL_TIME_S = 5;
    localparam int LALARM_QUAL_TICKS  = LALARM_QUAL_TIME_S * 1_000_000 / LALARM_TICK_US;

    localparam logic [4:0] LALARM_IDX_LOOP_CTRL = 5'h03;
    localparam logic [4:0] LALARM_IDX_IRQ_EN    = 5'h04;
    localparam logic [4:0] LALARM_IDX_LIVE      = 5'h05;
    localparam logic [4:0] LALARM_IDX_CHANGE    = 5'h06;

    localparam logic [1:0] LALARM_LOOP_CTRL_RST = 2'h0;
    localparam logic [7:0] LALARM_IRQ_EN_RST    = 8'h00;
    localparam logic [6:0] LALARM_CHANGE_RST    = 7'h00;

    localparam int LALARM_BIT_GIE  = 7;
    localparam int LALARM_BIT_LOOP = 3;
    localparam int LALARM_NSRC     = 7;

    typedef enum logic [1:0] {
        LALARM_LC_OFF,
        LALARM_LC_MANUAL,
        LALARM_LC_WAIT_UP,
        LALARM_LC_LOOPED
    } lalarm_lc_state_t;
endpackage
`default_nettype wire

/* core/lalarm_tick_div.sv */
// Purpose: Divides the system clock into a one-cycle tick enable.
// Assumes: DIV is at least two.
// Notes: The tick is a pulse, one cycle in every DIV.
`default_nettype none
module lalarm_tick_div
    import lalarm_pkg::*;
#(
    parameter int DIV = LALARM_TICK_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_n,
    output var  logic tick
);
    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] count_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_reg <= '0;
            tick      <= 1'b0;
        end else begin
            tick      <= (count_reg == LAST);
            count_reg <= (count_reg == LAST) ? '0 : count_reg + 1'b1;
        end
    end
endmodule
`default_nettype wire

/* core/lalarm_qual_timer.sv */
// Purpose: Qualifies a pattern that stays present for a whole period.
// Assumes: tick is a one-cycle enable from the divider.
// Notes: Counts LIMIT+1 ticks so a partial first tick never shortens the wait.
`default_nettype none
module lalarm_qual_timer
    import lalarm_pkg::*;
#(
    parameter int LIMIT = LALARM_QUAL_TICKS
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic tick,
    input  wire logic present,
    output var  logic qualified
);
    localparam int CW = $clog2(LIMIT + 2);
    localparam logic [CW-1:0] TOP = CW'(LIMIT + 1);

    logic [CW-1:0] count_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_reg <= '0;
            qualified <= 1'b0;
        end else if (!present) begin
            count_reg <= '0;
            qualified <= 1'b0;
        end else begin
            if (tick && count_reg != TOP) begin
                count_reg <= count_reg + 1'b1;
            end
            qualified <= (count_reg == TOP);
        end
    end
endmodule
`default_nettype wire

/* core/lalarm_top.sv */
// Purpose: Receive alarm status, loop-code detection and change status.
// Assumes: Detector inputs are levels synchronous to clk.
// Notes: APB slave with one wait state on every access.
// Notes on behaviour
// R01: Mode select 01 or 10 means manual loop-code detection.
// R02: Manual: flag sets after loop-up or loop-down present over 5 s.
// R03: Manual: flag holds while code arrives, drops once it stops.
// R04: Manual: every flag edge is an interrupt when enabled.
// R05: Mode 11 clears the flag on entry and watches for loop-up.
// R06: Auto: loop-up over 5 s sets flag, loop-back, then watch loop-down.
// R07: Auto: flag stays set while remote loop-back is active.
// R08: Auto: loop-down over 5 s ends loop-back, clears flag, interrupts.
// R09: Auto: any flag change is an interrupt.
// R10: Live all-ones alarm in status bit 2, edges interrupt.
// R11: Live signal loss in status bit 1, edges interrupt.
// R12: Live pattern sync in status bit 0, edges interrupt.
// R13: Change bit 6 marks a driver fault change since read.
// R14: Change bit 5 marks a jitter buffer limit change since read.
// R15: Change bit 4 marks a line code error change since read.
// R16: Change bit 3 marks a loop-code flag change since read.
// R17: Change bit 2 marks an all-ones alarm change since read.
// R18: Change bit 1 marks a signal loss change since read.
// R19: Change bit 0 marks a pattern sync change since read.
// R20: Reading change status returns bits and clears them; reset zero.
// R21: Interrupt output only while global enable bit 7 is set.
`default_nettype none
module lalarm_top
    import lalarm_pkg::*;
#(
    parameter int TICK_CYCLES = LALARM_TICK_CYCLES,
    parameter int QUAL_TICKS  = LALARM_QUAL_TICKS
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        loop_up_det,
    input  wire logic        loop_down_det,
    input  wire logic        all_ones_alarm_flag,
    input  wire logic        rx_signal_lost_flag,
    input  wire logic        test_pattern_sync_flag,
    input  wire logic        driver_fault_flag,
    input  wire logic        jitter_buffer_limit_flag,
    input  wire logic        line_code_error_flag,
    output var  logic        network_loop_code_flag,
    output var  logic        remote_loopback,
    output var  logic        irq_n
);
    logic                    tick;
    logic                    up_q;
    logic                    down_q;
    logic [1:0]              mode_reg;
    logic [7:0]              irq_en_reg;
    logic [6:0]              change_reg;
    logic [6:0]              change_next;
    logic [6:0]              live_prev_reg;
    logic [6:0]              live_now;
    logic [6:0]              change_set;
    lalarm_lc_state_t        lc_state_reg;
    logic                    mode_manual;
    logic                    mode_auto;
    logic                    access;
    logic                    xfer_done;
    logic [4:0]              idx;
    logic                    aligned;
    logic                    hit_ctrl;
    logic                    hit_en;
    logic                    hit_live;
    logic                    hit_change;
    logic                    mapped;
    logic                    rd_change;
    logic [7:0]              rd_value;

    lalarm_tick_div #(
        .DIV (TICK_CYCLES)
    ) u_div (
        .clk   (clk),
        .rst_n (rst_n),
        .tick  (tick)
    );

    lalarm_qual_timer #(
        .LIMIT (QUAL_TICKS)
    ) u_up_timer (
        .clk       (clk),
        .rst_n     (rst_n),
        .tick      (tick),
        .present   (loop_up_det),
        .qualified (up_q)
    );

    lalarm_qual_timer #(
        .LIMIT (QUAL_TICKS)
    ) u_down_timer (
        .clk       (clk),
        .rst_n     (rst_n),
        .tick      (tick),
        .present   (loop_down_det),
        .qualified (down_q)
    );

    // Bus decode.
    assign access    = psel && penable;
    assign xfer_done = access && pready;
    assign idx       = paddr[6:2];
    assign aligned   = (paddr[1:0] == 2'h0) && !paddr[7];

    always_comb begin
        hit_ctrl   = 1'b0;
        hit_en     = 1'b0;
        hit_live   = 1'b0;
        hit_change = 1'b0;
        if (!aligned) begin
            hit_ctrl = 1'b0;
        end else if (idx == LALARM_IDX_LOOP_CTRL) begin
            hit_ctrl = 1'b1;
        end else if (idx == LALARM_IDX_IRQ_EN) begin
            hit_en = 1'b1;
        end else if (idx == LALARM_IDX_LIVE) begin
            hit_live = 1'b1;
        end else if (idx == LALARM_IDX_CHANGE) begin
            hit_change = 1'b1;
        end
    end

    assign mapped    = hit_ctrl || hit_en || hit_live || hit_change;
    assign rd_change = xfer_done && !pwrite && hit_change;

    always_comb begin
        rd_value = 8'h00;
        if (hit_ctrl) begin
            rd_value = {6'h00, mode_reg};
        end else if (hit_en) begin
            rd_value = irq_en_reg;
        end else if (hit_live) begin
            rd_value = {1'b0, live_now}; // R10 R11 R12
        end else if (hit_change) begin
            rd_value = {1'b0, change_reg};
        end
    end

    // One wait state: read data and error are loaded at the first access edge.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= access && !pready;
            if (access && !pready) begin
                prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_value};
                pslverr <= !mapped;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_reg   <= LALARM_LOOP_CTRL_RST;
            irq_en_reg <= LALARM_IRQ_EN_RST;
        end else if (xfer_done && pwrite) begin
            if (hit_ctrl) begin
                mode_reg <= pwdata[1:0];
            end else if (hit_en) begin
                irq_en_reg <= pwdata[7:0];
            end
        end
    end

    // Loop-code detection.
    assign mode_manual = mode_reg[1] ^ mode_reg[0]; // R01
    assign mode_auto   = mode_reg[1] && mode_reg[0];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lc_state_reg           <= LALARM_LC_OFF;
            network_loop_code_flag <= 1'b0;
            remote_loopback        <= 1'b0;
        end else if (mode_manual) begin
            lc_state_reg           <= LALARM_LC_MANUAL;
            network_loop_code_flag <= up_q || down_q; // R02 R03
            remote_loopback        <= 1'b0;
        end else if (mode_auto) begin
            case (lc_state_reg)
                LALARM_LC_WAIT_UP: begin
                    if (up_q) begin
                        lc_state_reg           <= LALARM_LC_LOOPED; // R06
                        network_loop_code_flag <= 1'b1;
                        remote_loopback        <= 1'b1;
                    end
                end
                LALARM_LC_LOOPED: begin
                    if (down_q) begin
                        lc_state_reg           <= LALARM_LC_WAIT_UP; // R08
                        network_loop_code_flag <= 1'b0;
                        remote_loopback        <= 1'b0;
                    end else begin
                        network_loop_code_flag <= 1'b1; // R07
                    end
                end
                default: begin
                    lc_state_reg           <= LALARM_LC_WAIT_UP; // R05
                    network_loop_code_flag <= 1'b0;
                    remote_loopback        <= 1'b0;
                end
            endcase
        end else begin
            lc_state_reg           <= LALARM_LC_OFF;
            network_loop_code_flag <= 1'b0;
            remote_loopback        <= 1'b0;
        end
    end

    // Change status: a set in the clearing cycle survives, and only the bits
    // already returned to software are cleared.
    assign live_now = {driver_fault_flag, jitter_buffer_limit_flag,
                       line_code_error_flag, network_loop_code_flag,
                       all_ones_alarm_flag, rx_signal_lost_flag,
                       test_pattern_sync_flag};
    assign change_set = live_now ^ live_prev_reg;

    generate
        for (genvar i = 0; i < LALARM_NSRC; i++) begin : g_change
            always_comb begin
                change_next[i] = change_reg[i];
                if (rd_change && prdata[i]) begin
                    change_next[i] = 1'b0; // R20
                end
                if (change_set[i]) begin
                    change_next[i] = 1'b1; // R13 R14 R15 R16 R17 R18 R19
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            live_prev_reg <= 7'h00;
            change_reg    <= LALARM_CHANGE_RST;
        end else begin
            live_prev_reg <= live_now;
            change_reg    <= change_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_n <= 1'b1;
        end else begin
            irq_n <= !(irq_en_reg[LALARM_BIT_GIE] && // R21
                       |(change_reg & irq_en_reg[6:0])); // R04 R09
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    manual_flag_set_a: assert property ( // R02
        mode_manual && (up_q || down_q) |=> network_loop_code_flag)
        else $error("Manual loop-code flag failed to set.");

    manual_flag_drop_a: assert property ( // R03
        mode_manual && !up_q && !down_q |=> !network_loop_code_flag)
        else $error("Manual loop-code flag failed to drop.");

    manual_mode_a: assert property ( // R01
        mode_manual |=> lc_state_reg == LALARM_LC_MANUAL && !remote_loopback)
        else $error("Manual mode select not honoured.");

    manual_edge_a: assert property ( // R04
        mode_manual && $fell(network_loop_code_flag) |=> change_reg[LALARM_BIT_LOOP])
        else $error("Manual loop-code fall was not latched.");

    auto_entry_a: assert property ( // R05
        mode_auto && (lc_state_reg == LALARM_LC_OFF || lc_state_reg == LALARM_LC_MANUAL)
        |=> !network_loop_code_flag && lc_state_reg == LALARM_LC_WAIT_UP)
        else $error("Automatic mode entry did not clear the flag.");

    auto_loop_on_a: assert property ( // R06
        mode_auto && lc_state_reg == LALARM_LC_WAIT_UP && up_q
        |=> network_loop_code_flag && remote_loopback && lc_state_reg == LALARM_LC_LOOPED)
        else $error("Loop-up did not start remote loop-back.");

    auto_hold_a: assert property ( // R07
        mode_auto && lc_state_reg == LALARM_LC_LOOPED && !down_q
        |=> network_loop_code_flag && remote_loopback)
        else $error("Flag dropped during remote loop-back.");

    auto_loop_off_a: assert property ( // R08
        mode_auto && lc_state_reg == LALARM_LC_LOOPED && down_q
        |=> !network_loop_code_flag && !remote_loopback ##1 change_reg[LALARM_BIT_LOOP])
        else $error("Loop-down did not end remote loop-back.");

    change_set_a: assert property ( // R16
        $changed(network_loop_code_flag) |=> change_reg[LALARM_BIT_LOOP])
        else $error("Loop-code change was not latched.");

    change_latch_a: assert property ( // R13 R14 R15 R17 R18 R19
        |change_set |=> (change_reg & $past(change_set)) == $past(change_set))
        else $error("Status change was not latched.");

    read_clear_a: assert property ( // R20
        rd_change |=> (change_reg & $past(prdata[6:0]) & ~$past(change_set)) == 7'h00)
        else $error("Change status was not cleared by its read.");

    live_read_a: assert property ( // R10 R11 R12
        access && !pready && !pwrite && hit_live
        |=> pready && prdata[6:0] == $past(live_now))
        else $error("Live status read returned stale data.");

    irq_gate_a: assert property ( // R21
        !irq_en_reg[LALARM_BIT_GIE] |=> irq_n)
        else $error("Interrupt driven while globally masked.");

    irq_event_a: assert property ( // R04 R09
        change_reg[LALARM_BIT_LOOP] && irq_en_reg[LALARM_BIT_LOOP] && irq_en_reg[LALARM_BIT_GIE]
        |=> !irq_n)
        else $error("Enabled loop-code change did not interrupt.");

    auto_cycle_c: cover property (
        lc_state_reg == LALARM_LC_LOOPED ##1 lc_state_reg == LALARM_LC_WAIT_UP);

    manual_rise_c: cover property (
        mode_manual && $rose(network_loop_code_flag));

    manual_fall_c: cover property (
        mode_manual && $fell(network_loop_code_flag));

    read_clear_c: cover property (
        rd_change && |prdata[6:0]);

    irq_c: cover property (
        $fell(irq_n));
endmodule
`default_nettype wire

/* sim/lalarm_host.sv */
// Purpose: APB master standing in for the host processor.
// Assumes: One transfer at a time, called from the bench.
// Notes: Signals change only by non-blocking assignment after a rising edge.
`default_nettype none
module lalarm_host (
    input  wire logic        clk,
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [7:0]  paddr,
    output var  logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
    end

    // The request is held until pready is sampled high at a rising edge.
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        err   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* sim/test_line_alarm_status_and_loop_code_irq.sv */
// Purpose: Self-checking bench of the line alarm status block.
// Assumes: Short tick and qualification counts keep the run brief.
// Notes: Expected change bits come from a model of the driven flags.
`default_nettype none
module test_line_alarm_status_and_loop_code_irq;
    timeunit 1ns;
    timeprecision 1ps;
    import lalarm_pkg::*;

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        up_det = 1'b0;
    logic        down_det = 1'b0;
    logic [6:0]  flags = 7'h00;
    logic        loop_flag, loopback, irq_n, err;
    logic [7:0]  bad [3] = '{8'h1c, 8'h0d, 8'h94};
    int          mismatches = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int          seed = 32'h6fa9;
    int          exp_chg, en, v;

    lalarm_host host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    lalarm_top #(.TICK_CYCLES(4), .QUAL_TICKS(3)) dut (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .loop_up_det(up_det), .loop_down_det(down_det),
        .all_ones_alarm_flag(flags[2]), .rx_signal_lost_flag(flags[1]),
        .test_pattern_sync_flag(flags[0]), .driver_fault_flag(flags[6]),
        .jitter_buffer_limit_flag(flags[5]), .line_code_error_flag(flags[4]),
        .network_loop_code_flag(loop_flag), .remote_loopback(loopback), .irq_n(irq_n));

    initial begin
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (mismatches == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        checks_done++;
        if (seen !== expv) begin
            mismatches++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, expv);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] expv);
        host.xfer(1'b0, a, 32'h0, rd, err);
        check(rd, expv);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rd, err);
    endtask

    // Waits a bounded time for the loop-code flag to reach a level.
    task automatic wait_flag(input logic lvl);
        int n;
        n = 0;
        while (loop_flag !== lvl && n < 40) begin
            @(posedge clk);
            n++;
        end
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(8'h0c, 32'h0);
        rd_chk(8'h10, 32'h0);
        rd_chk(8'h18, 32'h0);
        check(irq_n, 1'b1);
        foreach (bad[i]) begin
            host.xfer(1'b0, bad[i], 32'h0, rd, err);
            check(rd, 32'h0);
            check(err, 1'b1);
        end
        host.xfer(1'b1, 8'h8c, 32'h3, rd, err);
        check(err, 1'b1);
        rd_chk(8'h0c, 32'h0);
        exp_chg = 0;
        for (int i = 0; i < 24; i++) begin
            en = $random(seed) & 32'hff;
            v  = $random(seed) & 32'h77;
            wr(8'h10, en);
            exp_chg = exp_chg | ((v ^ flags) & 32'h77);
            @(posedge clk);
            flags <= v[6:0];
            repeat (4) @(posedge clk);
            check(irq_n, !(en[7] && (exp_chg & en & 32'h7f) != 0));
            rd_chk(8'h14, v);
            rd_chk(8'h18, exp_chg);
            exp_chg = 0;
            repeat (3) @(posedge clk);
            check(irq_n, 1'b1);
        end
        wr(8'h10, 32'h88);
        for (int m = 1; m <= 2; m++) begin
            for (int p = 0; p < 2; p++) begin
                wr(8'h0c, m);
                @(posedge clk);
                if (p == 0) up_det <= 1'b1; else down_det <= 1'b1;
                repeat (8) @(posedge clk);
                check(loop_flag, 1'b0);
                wait_flag(1'b1);
                check(loop_flag, 1'b1);
                repeat (4) @(posedge clk);
                check({loop_flag, irq_n}, 2'b10);
                rd_chk(8'h18, 32'h08);
                up_det <= 1'b0;
                down_det <= 1'b0;
                repeat (6) @(posedge clk);
                check({loop_flag, irq_n}, 2'b00);
                rd_chk(8'h18, 32'h08);
            end
        end
        wr(8'h0c, 32'h1);
        up_det <= 1'b1;
        wait_flag(1'b1);
        wr(8'h0c, 32'h3);
        up_det <= 1'b0;
        down_det <= 1'b1;
        repeat (3) @(posedge clk);
        check({loop_flag, loopback}, 2'b00);
        repeat (40) @(posedge clk);
        check(loop_flag, 1'b0);
        down_det <= 1'b0;
        up_det <= 1'b1;
        wait_flag(1'b1);
        check({loop_flag, loopback}, 2'b11);
        up_det <= 1'b0;
        repeat (40) @(posedge clk);
        check({loop_flag, loopback}, 2'b11);
        rd_chk(8'h18, 32'h08);
        down_det <= 1'b1;
        wait_flag(1'b0);
        repeat (4) @(posedge clk);
        check({loop_flag, loopback, irq_n}, 3'b000);
        rd_chk(8'h18, 32'h08);
        down_det <= 1'b0;
        wr(8'h0c, 32'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
